// [osd_pkg.sv]
// Purpose: constants and types for the oscillator start-up delay block
// Assumes: one clock mclk_i at 25 MHz, asynchronous active-low reset
// Notes: oscillator pin edges are sampled, never used as a clock
//
// How it works
// RULE1: Crystal modes count 1024 oscillator edges before releasing the clock.
// RULE2: Count starts after power-on, power-up timer expiry and sleep wake.
// RULE3: Execution hold stays asserted while the start-up count is running.
// RULE4: External-clock mode skips the start-up count entirely.
// RULE5: External-clock mode uses the input pin; output pin freed for I/O.
// RULE6: State is fully static; a stopped oscillator just pauses the count.
// RULE7: Any clock-source change inserts a stabilisation delay before use.
// RULE8: Three-bit configuration field selects the clock source.
// RULE9: Each trigger restarts the count from zero; release needs full count.
package osd_pkg;

    // ****************************************
    // Clock source encodings
    // ****************************************
    localparam logic [2:0] OSD_SRC_LP = 3'h0;
    localparam logic [2:0] OSD_SRC_XT = 3'h1;
    localparam logic [2:0] OSD_SRC_HS = 3'h2;
    localparam logic [2:0] OSD_SRC_EC = 3'h3;
    localparam logic [2:0] OSD_SRC_INT = 3'h4;
    localparam logic [2:0] OSD_SRC_RC = 3'h6;

    // ****************************************
    // Counts
    // ****************************************
    localparam int OSD_OST_COUNT = 1024;
    localparam int OSD_EC_INSTR_CYCLES = 2;
    localparam int OSD_CLKS_PER_INSTR = 4;
    localparam int OSD_EC_DELAY = OSD_EC_INSTR_CYCLES * OSD_CLKS_PER_INSTR;
    localparam int OSD_WARM_DELAY = 64;
    localparam logic [10:0] OSD_CNT_RESET = 11'h000;

    typedef enum logic [3:0] {
        OSD_ST_IDLE = 4'b0001,
        OSD_ST_OST = 4'b0010,
        OSD_ST_WAIT = 4'b0100,
        OSD_ST_RUN = 4'b1000
    } osd_state_t;

    typedef struct packed {
        logic por;
        logic power_up_timer_en;
        logic power_up_timer_done;
        logic wake;
        logic [2:0] fosc;
    } osd_ctrl_t;

    typedef struct packed {
        osd_state_t st;
        logic [10:0] cnt;
        logic [2:0] src;
        logic hold;
        logic por_pend;
        logic osc_prev;
    } osd_core_t;

endpackage

// [osd_sync.sv]
// Purpose: two-flop synchroniser for the oscillator input pin
// Assumes: pin asynchronous to mclk_i
// Notes: first stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
module osd_sync
    import osd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic d_i,
    output logic q_o
);

    typedef struct packed {
        logic s1;
        logic s2;
    } osd_sync_t;

    osd_sync_t sync_q;
    osd_sync_t sync_d;

    always_comb
    begin
        sync_d.s1 = d_i;
        sync_d.s2 = sync_q.s1;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync_q <= '0;
        end
        else
        begin
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q.s2;

endmodule
`default_nettype wire

// [osd_core.sv]
// Purpose: start-up hold-off for the system clock source
// Assumes: trigger inputs are synchronous to mclk_i; crystal_in_pin is not
// Notes: counts rising edges of the sampled oscillator pin
`timescale 1ns/1ns
`default_nettype none
module osd_core
    import osd_pkg::*;
#(
    parameter int OST_COUNT = OSD_OST_COUNT,
    parameter int EC_DELAY = OSD_EC_DELAY,
    parameter int WARM_DELAY = OSD_WARM_DELAY
)
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire osd_ctrl_t ctrl_i,
    input wire logic crystal_in_pin_i,
    output logic hold_exec_o,
    output logic clk_ready_o,
    output logic crystal_out_pin_free_o,
    output logic [2:0] active_src_o
);

    // ****************************************
    // Parameter checks
    // ****************************************
    if (OST_COUNT < 2 || OST_COUNT > 2047 || EC_DELAY < 1 ||
        EC_DELAY > 2047 || WARM_DELAY < 1 || WARM_DELAY > 2047)
    begin : g_bad
        $error("osd_core: delay counts out of range");
    end

    localparam logic [10:0] OST_LAST = 11'(OST_COUNT - 1);
    localparam logic [10:0] EC_LAST = 11'(EC_DELAY - 1);
    localparam logic [10:0] WARM_LAST = 11'(WARM_DELAY - 1);

    logic osc_s;
    osd_core_t core_q;
    osd_core_t core_d;
    logic crystal;
    logic osc_edge;
    logic trigger;
    logic src_change;
    logic [10:0] last;

    osd_sync u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .d_i(crystal_in_pin_i),
        .q_o(osc_s)
    );

    // ****************************************
    // Start-up sequencer
    // ****************************************
    always_comb
    begin
        crystal = (ctrl_i.fosc == OSD_SRC_LP) || (ctrl_i.fosc == OSD_SRC_XT)
            || (ctrl_i.fosc == OSD_SRC_HS);
        osc_edge = osc_s && !core_q.osc_prev;
        // RULE7: source change restarts
        src_change = (core_q.st == OSD_ST_RUN) && (ctrl_i.fosc != core_q.src);
        // RULE2: por waits for power-up timer
        trigger = (core_q.por_pend && (!ctrl_i.power_up_timer_en || ctrl_i.power_up_timer_done))
            || ctrl_i.wake || src_change;
        // RULE4: external clock gets short delay
        if (ctrl_i.fosc == OSD_SRC_EC || ctrl_i.fosc == OSD_SRC_RC)
        begin
            last = EC_LAST;
        end
        else
        begin
            last = WARM_LAST;
        end
        core_d = core_q;
        core_d.osc_prev = osc_s;
        if (ctrl_i.por)
        begin
            core_d.por_pend = 1'b1;
        end
        case (core_q.st)
            OSD_ST_IDLE:
            begin
                core_d.hold = 1'b1;
            end
            OSD_ST_OST:
            begin
                // RULE1: count oscillator edges
                // RULE6: stopped oscillator pauses count
                if (osc_edge)
                begin
                    if (core_q.cnt == OST_LAST)
                    begin
                        core_d.st = OSD_ST_RUN;
                        core_d.hold = 1'b0;
                    end
                    else
                    begin
                        core_d.cnt = core_q.cnt + 11'h001;
                    end
                end
            end
            OSD_ST_WAIT:
            begin
                if (core_q.cnt == last)
                begin
                    core_d.st = OSD_ST_RUN;
                    core_d.hold = 1'b0;
                end
                else
                begin
                    core_d.cnt = core_q.cnt + 11'h001;
                end
            end
            OSD_ST_RUN:
            begin
                core_d.hold = 1'b0;
            end
            default:
            begin
                core_d.st = OSD_ST_IDLE;
                core_d.hold = 1'b1;
            end
        endcase
        // RULE9: every trigger restarts count
        if (trigger && !ctrl_i.por)
        begin
            core_d.por_pend = 1'b0;
            core_d.cnt = OSD_CNT_RESET;
            core_d.hold = 1'b1;
            // RULE8: configuration selects source
            core_d.src = ctrl_i.fosc;
            core_d.st = crystal ? OSD_ST_OST : OSD_ST_WAIT;
        end
        else if (ctrl_i.por)
        begin
            core_d.st = OSD_ST_IDLE;
            core_d.hold = 1'b1;
            core_d.cnt = OSD_CNT_RESET;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            core_q.st <= OSD_ST_IDLE;
            core_q.cnt <= OSD_CNT_RESET;
            core_q.src <= OSD_SRC_LP;
            core_q.hold <= 1'b1;
            core_q.por_pend <= 1'b1;
            core_q.osc_prev <= 1'b0;
        end
        else
        begin
            core_q <= core_d;
        end
    end

    // RULE3: hold execution while counting
    assign hold_exec_o = core_q.hold;
    assign clk_ready_o = !core_q.hold;
    // RULE5: external clock frees output pin
    assign crystal_out_pin_free_o = (core_q.src == OSD_SRC_EC);
    assign active_src_o = core_q.src;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_ost_start;
        $rose(core_q.st == OSD_ST_OST);
    endsequence

    a_hold_while_ost: assert property (@(posedge mclk_i) // RULE3
        disable iff (!arst_n_i)
        (core_q.st == OSD_ST_OST) |-> hold_exec_o)
        else $error("execution released during start-up count");

    a_ost_restart_zero: assert property (@(posedge mclk_i) // RULE9
        disable iff (!arst_n_i)
        s_ost_start |-> core_q.cnt == OSD_CNT_RESET)
        else $error("start-up count not restarted from zero");

    a_release_full_count: assert property (@(posedge mclk_i) // RULE1
        disable iff (!arst_n_i)
        $fell(hold_exec_o) && $past(core_q.st) == OSD_ST_OST
        |-> $past(core_q.cnt) == OST_LAST)
        else $error("release before full oscillator count");

    a_stopped_osc_static: assert property (@(posedge mclk_i) // RULE6
        disable iff (!arst_n_i)
        (core_q.st == OSD_ST_OST) && !osc_edge && !trigger && !ctrl_i.por
        |=> $stable(core_q.cnt))
        else $error("count moved without oscillator edge");

    a_ec_no_ost: assert property (@(posedge mclk_i) // RULE4
        disable iff (!arst_n_i)
        trigger && !ctrl_i.por && ctrl_i.fosc == OSD_SRC_EC
        |=> core_q.st == OSD_ST_WAIT)
        else $error("start-up count used in external clock mode");

    a_ec_release_time: assert property (@(posedge mclk_i) // RULE4
        disable iff (!arst_n_i)
        trigger && !ctrl_i.por && ctrl_i.fosc == OSD_SRC_EC
        ##1 (!trigger && !ctrl_i.por && ctrl_i.fosc == OSD_SRC_EC)[*8]
        |=> !hold_exec_o)
        else $error("external clock delay too long");

    a_pin_free_ec: assert property (@(posedge mclk_i) // RULE5
        disable iff (!arst_n_i)
        crystal_out_pin_free_o |-> active_src_o == OSD_SRC_EC)
        else $error("output pin freed outside external clock mode");

    a_pin_free_cause: assert property (@(posedge mclk_i) // RULE5
        disable iff (!arst_n_i)
        $rose(crystal_out_pin_free_o)
        |-> $past(trigger && !ctrl_i.por && ctrl_i.fosc == OSD_SRC_EC))
        else $error("output pin freed without external clock selection");

    a_wake_restart: assert property (@(posedge mclk_i) // RULE2
        disable iff (!arst_n_i)
        ctrl_i.wake && !ctrl_i.por |=> hold_exec_o)
        else $error("wake did not restart hold-off");

    a_switch_delay: assert property (@(posedge mclk_i) // RULE7
        disable iff (!arst_n_i)
        src_change && !ctrl_i.por |=> hold_exec_o)
        else $error("source switch without stabilisation delay");

endmodule
`default_nettype wire

// [osd_osc_model.sv]
// Purpose: crystal or clock source on the oscillator input pin
// Assumes: half period given in mclk_i cycles
// Notes: a stopped source freezes its level, as a halted crystal does
`timescale 1ns/1ns
`default_nettype none
module osd_osc_model #(
    parameter int HALF = 2
)
(
    input wire logic mclk_i,
    input wire logic run_i,
    output logic pin_o
);
    int cnt = 0;
    initial pin_o = 1'b0;
    always @(posedge mclk_i)
    begin
        if (run_i)
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
                pin_o <= ~pin_o;
        end
    end
endmodule
`default_nettype wire

// [oscillator_startup_delay_tb_top.sv]
// Purpose: self-checking bench for the start-up delay block
// Assumes: count shortened to 8 oscillations, warm delay to 16
// Notes: only mismatches and the verdict are printed
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
 $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module oscillator_startup_delay_tb_top;
    import osd_pkg::*;
    localparam int OSCILLATOR_STARTUP_TIMER = 8;
    localparam int WARM = 16;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    osd_ctrl_t ctrl = '0;
    logic osc_run = 1'b0;
    logic pin;
    logic hold;
    logic ready;
    logic pfree;
    logic [2:0] src;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    osd_osc_model i_osd_osc_model (.mclk_i(mclk_i), .run_i(osc_run),
        .pin_o(pin));
    osd_core #(.OST_COUNT(OSCILLATOR_STARTUP_TIMER), .WARM_DELAY(WARM)) i_osd_core (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ctrl_i(ctrl),
        .crystal_in_pin_i(pin), .hold_exec_o(hold), .clk_ready_o(ready),
        .crystal_out_pin_free_o(pfree), .active_src_o(src));
    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic end_of_test;
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_rel(input int lim);
        for (int i = 0; i < lim && hold !== 1'b0; i++)
        begin
            @(posedge mclk_i);
            #1;
        end
        `CHK(hold, 1'b0)
        `CHK(ready, 1'b1)
    endtask
    // Sum of held cycles over a fixed window; optional second wake
    task automatic trig_count(input logic [2:0] f, input logic wk,
        input int gap, output int sum);
        sum = 0;
        for (int i = 0; i < 60; i++)
        begin
            @(posedge mclk_i);
            if (i == 0)
                ctrl.fosc <= f;
            ctrl.wake <= (i == 0) ? wk : (i == gap);
            #1;
            sum += (hold === 1'b1);
        end
    endtask
    task automatic xtal(input logic [2:0] f);
        int e;
        logic prv;
        e = 0;
        @(posedge mclk_i);
        ctrl.fosc <= f;
        ctrl.wake <= 1'b1;
        @(posedge mclk_i);
        ctrl.wake <= 1'b0;
        repeat (40) @(posedge mclk_i);
        `CHK(hold, 1'b1)
        osc_run <= 1'b1;
        prv = pin;
        for (int i = 0; i < 400 && hold !== 1'b0; i++)
        begin
            @(posedge mclk_i);
            e += (pin && !prv);
            prv = pin;
            if (e == 3 && i < 200)
            begin
                osc_run <= 1'b0;
                repeat (30) @(posedge mclk_i);
                `CHK(hold, 1'b1)
                osc_run <= 1'b1;
                i = 200;
            end
            #1;
        end
        osc_run <= 1'b0;
        `CHK(e >= OSCILLATOR_STARTUP_TIMER && e <= OSCILLATOR_STARTUP_TIMER + 1, 1'b1)
        `CHK(pfree, 1'b0)
        `CHK(src, f)
        wait_rel(2);
    endtask
    task automatic por_start;
        @(posedge mclk_i);
        ctrl.power_up_timer_en <= 1'b1;
        osc_run <= 1'b1;
        repeat (7) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(negedge mclk_i);
        `CHK({hold, ready, pfree, src}, 6'h20)
        repeat (60) @(posedge mclk_i);
        `CHK(hold, 1'b1)
        ctrl.power_up_timer_done <= 1'b1;
        wait_rel(200);
        `CHK(src, OSD_SRC_LP)
        osc_run <= 1'b0;
    endtask
    task automatic ec_rc;
        trig_count(OSD_SRC_EC, 1'b0, -1, n);
        `CHK(n, OSD_EC_DELAY)
        `CHK(pfree, 1'b1)
        trig_count(OSD_SRC_EC, 1'b1, 3, n);
        `CHK(n, 3 + OSD_EC_DELAY)
        trig_count(OSD_SRC_RC, 1'b0, -1, n);
        `CHK(n, OSD_EC_DELAY)
        `CHK(pfree, 1'b0)
        trig_count(OSD_SRC_INT, 1'b0, -1, n);
        `CHK(n, WARM)
    endtask
    task automatic por_again;
        @(posedge mclk_i);
        ctrl.por <= 1'b1;
        ctrl.power_up_timer_en <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        `CHK({hold, ready}, 2'h2)
        @(posedge mclk_i);
        ctrl.por <= 1'b0;
        repeat (5) @(posedge mclk_i);
        `CHK(hold, 1'b1)
        wait_rel(100);
    endtask
    initial
    begin
        por_start();
        xtal(OSD_SRC_XT);
        xtal(OSD_SRC_HS);
        ec_rc();
        por_again();
        end_of_test();
    end
    initial
    begin
        #(40 * 20000);
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
